//--- hw/serial_sram_command_port.sv
// serial sram command port: instruction decode, addressing, modes, multi-line io
// What this block does
// - write ends when select returns high; no more write data taken
// - page mode accepts further bytes, pointer increments, 32 bytes before overwrite
// - sequential mode keeps taking write bytes, pointer increments up to die boundary
// - after read opcode and address, stored byte shifts out on serial output
// - sequential read keeps supplying next addresses while clocked, up to die boundary
// - opcode 03h reads the array, 02h writes it, from the given address
// - opcode 3Bh switches the port to dual line mode
// - opcode 38h switches the port to quad line mode
// - opcode FFh returns dual or quad operation to single line
// - opcode 05h returns the mode register, allowed at any time
// - mode bits 7:6 pick byte 00, page 10, sequential 01; 11 reserved
// - after initialisation the port runs sequential mode until reprogrammed
// - opcode 01h stores the next byte in the mode register
// - dual mode moves two bits per clock on lines 0 and 1, msb first
// - quad mode moves one nibble per clock on four lines, msb first
// - dual byte read inserts four dummy clocks after the address
// - dual write takes data right after the address, no latency
// - select high deselects, outputs float, any sequence in progress is dropped
// - inputs sampled on rising serial clock, outputs change after falling edge
// - page mode address wraps to the start of the same 32-byte page
// - sequential address rolls from 3FFFFh to 00000h, not to 40000h
`timescale 1ns/1ps
`default_nettype none
`include "sram_port_defines.svh"
module serial_sram_command_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = `MEM_ADDR_W,
  parameter int QUAD_DUMMY = `QUAD_DUMMY_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_line_in,
  output logic [3:0] io_line_out,
  output logic [3:0] io_line_oe,
  output logic deselected,
  output logic [1:0] width_status,
  output logic [1:0] mode_status
);

  generate
    if (ADDR_W < 19 || ADDR_W > 24 || QUAD_DUMMY < 1 || QUAD_DUMMY > 15) begin : g_check
      $error("serial_sram_command_port: unsupported ADDR_W or QUAD_DUMMY");
    end
  endgenerate

  localparam logic [3:0] DUAL_DUMMY_LAST = 4'(`DUAL_DUMMY_CYCLES - 1);
  localparam logic [3:0] QUAD_DUMMY_LAST = 4'(QUAD_DUMMY - 1);
  localparam logic [ADDR_W-1:0] DIE0_LAST = ADDR_W'(`DIE0_LAST);

  // link reset is held in the system domain and only ever forces constants
  logic link_rst;
  always_ff @(posedge clk) begin
    link_rst <= ~rstn;
  end

  wire frame_rst = cs_n | link_rst;

  // persistent state, survives deselection
  io_width_t io_width;
  logic [7:0] mode_reg;

  // frame state, cleared whenever select is high
  frame_state_t state;
  frame_state_t next_state;
  logic is_write;
  logic next_is_write;
  logic [3:0] cnt;
  logic [7:0] rx_sh;
  logic [15:0] addr_sh;
  logic [1:0] byte_idx;
  logic [3:0] dummy_cnt;
  logic [ADDR_W-1:0] addr;
  logic mem_we;
  logic mode_we;
  logic width_we;
  io_width_t next_width;
  logic [7:0] mem_rdata;

  // transmit side, falling edge
  logic [7:0] tx_sh;
  logic [3:0] tx_pos;

  wire [3:0] lanes = (io_width == IO_QUAD) ? 4'h4 : (io_width == IO_DUAL) ? 4'h2 : 4'h1;
  wire [3:0] cnt_sum = cnt + lanes;
  wire byte_done = (cnt_sum == 4'h8);

  wire [7:0] rx_byte = (io_width == IO_QUAD) ? {rx_sh[3:0], io_line_in[3:0]} :
                       (io_width == IO_DUAL) ? {rx_sh[5:0], io_line_in[1:0]} :
                       {rx_sh[6:0], io_line_in[0]};

  wire [23:0] full_addr = {addr_sh, rx_byte};
  wire [ADDR_W-1:0] new_addr = full_addr[ADDR_W-1:0];

  // mode field decode; reserved 11 behaves as sequential
  wire [1:0] op_mode = mode_reg[`MODE_FIELD_HI:`MODE_FIELD_LO];
  wire mode_is_byte = (op_mode == `MODE_BYTE);
  wire mode_is_page = (op_mode == `MODE_PAGE);

  wire [`PAGE_BITS-1:0] page_next = addr[`PAGE_BITS-1:0] + `PAGE_BITS'(1);
  wire [ADDR_W-1:0] addr_page = {addr[ADDR_W-1:`PAGE_BITS], page_next};
  wire [ADDR_W-1:0] addr_seq = (addr == DIE0_LAST) ? '0 : addr + ADDR_W'(1);
  wire [ADDR_W-1:0] next_addr = mode_is_page ? addr_page : addr_seq;

  wire need_dummy = (io_width != IO_SINGLE);
  wire [3:0] dummy_last = (io_width == IO_QUAD) ? QUAD_DUMMY_LAST : DUAL_DUMMY_LAST;

  always_comb begin
    next_state = state;
    next_is_write = is_write;
    mem_we = 1'b0;
    mode_we = 1'b0;
    width_we = 1'b0;
    next_width = io_width;
    case (state)
      ST_CMD: begin
        if (byte_done) begin
          case (rx_byte)
            `OP_READ: begin
              next_state = ST_ADDR;
              next_is_write = 1'b0;
            end
            `OP_WRITE: begin
              next_state = ST_ADDR;
              next_is_write = 1'b1;
            end
            `OP_READ_MODE: next_state = ST_MODE_READ;
            `OP_WRITE_MODE: next_state = ST_MODE_WRITE;
            `OP_ENTER_DUAL: begin
              width_we = 1'b1;
              next_width = IO_DUAL;
              next_state = ST_DONE;
            end
            `OP_ENTER_QUAD: begin
              width_we = 1'b1;
              next_width = IO_QUAD;
              next_state = ST_DONE;
            end
            `OP_EXIT_MULTI: begin
              width_we = 1'b1;
              next_width = IO_SINGLE;
              next_state = ST_DONE;
            end
            default: next_state = ST_DONE;
          endcase
        end
      end
      ST_ADDR: begin
        if (byte_done && byte_idx == (`ADDR_BYTES - 2'h1)) begin
          if (is_write) begin
            next_state = ST_WRITE_DATA;
          end else if (need_dummy) begin
            next_state = ST_DUMMY;
          end else begin
            next_state = ST_READ_DATA;
          end
        end
      end
      ST_DUMMY: begin
        if (dummy_cnt == dummy_last) begin
          next_state = ST_READ_DATA;
        end
      end
      ST_READ_DATA: begin
        if (byte_done && mode_is_byte) begin
          next_state = ST_DONE;
        end
      end
      ST_WRITE_DATA: begin
        if (byte_done) begin
          mem_we = 1'b1;
          if (mode_is_byte) begin
            next_state = ST_DONE;
          end
        end
      end
      ST_MODE_WRITE: begin
        if (byte_done) begin
          mode_we = 1'b1;
          next_state = ST_DONE;
        end
      end
      default: next_state = state;
    endcase
  end

  always_ff @(posedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      state <= ST_CMD;
      is_write <= 1'b0;
      cnt <= 4'h0;
      rx_sh <= 8'h00;
      addr_sh <= 16'h0000;
      byte_idx <= 2'h0;
      dummy_cnt <= 4'h0;
      addr <= '0;
    end else begin
      state <= next_state;
      is_write <= next_is_write;
      cnt <= (byte_done || state == ST_DUMMY) ? 4'h0 : cnt_sum;
      rx_sh <= rx_byte;
      dummy_cnt <= (state == ST_DUMMY) ? dummy_cnt + 4'h1 : 4'h0;
      if (state == ST_ADDR && byte_done) begin
        addr_sh <= full_addr[15:0];
        byte_idx <= byte_idx + 2'h1;
        if (next_state != ST_ADDR) begin
          addr <= new_addr;
        end
      end else if ((state == ST_READ_DATA || state == ST_WRITE_DATA) && byte_done) begin
        addr <= next_addr;
      end
    end
  end

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      mode_reg <= `MODE_RESET;
      io_width <= IO_SINGLE;
    end else begin
      if (mode_we) begin
        mode_reg <= rx_byte;
      end
      if (width_we) begin
        io_width <= next_width;
      end
    end
  end

  sram_byte_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .sck(sck),
    .we(mem_we),
    .addr(addr),
    .wdata(rx_byte),
    .rdata(mem_rdata)
  );

  wire driving = (state == ST_READ_DATA) || (state == ST_MODE_READ);
  wire [7:0] tx_cur = (tx_pos == 4'h0) ? ((state == ST_MODE_READ) ? mode_reg : mem_rdata)
                                       : tx_sh;
  wire [3:0] tx_out = (io_width == IO_QUAD) ? tx_cur[7:4] :
                      (io_width == IO_DUAL) ? {2'b00, tx_cur[7:6]} :
                      {2'b00, tx_cur[7], 1'b0};
  wire [3:0] tx_oe = (io_width == IO_QUAD) ? 4'hf : (io_width == IO_DUAL) ? 4'h3 : 4'h2;
  wire [3:0] tx_pos_sum = tx_pos + lanes;
  wire [7:0] tx_shifted = (io_width == IO_QUAD) ? {tx_cur[3:0], 4'h0} :
                          (io_width == IO_DUAL) ? {tx_cur[5:0], 2'b00} :
                          {tx_cur[6:0], 1'b0};

  always_ff @(negedge sck or posedge frame_rst) begin
    if (frame_rst) begin
      tx_sh <= 8'h00;
      tx_pos <= 4'h0;
      io_line_out <= 4'h0;
      io_line_oe <= 4'h0;
    end else if (driving) begin
      tx_sh <= tx_shifted;
      tx_pos <= (tx_pos_sum == 4'h8) ? 4'h0 : tx_pos_sum;
      io_line_out <= tx_out;
      io_line_oe <= tx_oe;
    end else begin
      io_line_out <= 4'h0;
      io_line_oe <= 4'h0;
    end
  end

  // status for the system side; quasi-static levels, so per-bit sync is enough
  logic [4:0] status_sync;
  sync_2ff #(
    .WIDTH(5),
    .RESET_VAL(5'h11)
  ) u_status_sync (
    .clk(clk),
    .rstn(rstn),
    .d({cs_n, io_width, op_mode}),
    .q(status_sync)
  );

  assign deselected = status_sync[4];
  assign width_status = status_sync[3:2];
  assign mode_status = status_sync[1:0];

endmodule
`default_nettype wire

//--- hw/sram_byte_array.sv
// byte-wide storage array, written on the serial clock
`timescale 1ns/1ps
`default_nettype none
module sram_byte_array #(
  parameter int ADDR_W = 19
) (
  input wire logic sck,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1 << ADDR_W)-1];

  // contents survive deselection and reset, as in a real sram
  always_ff @(posedge sck) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule
`default_nettype wire

//--- hw/sync_2ff.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

//--- shared/sram_port_defines.svh
// constants for the serial sram command port
`ifndef SRAM_PORT_DEFINES_SVH
`define SRAM_PORT_DEFINES_SVH

// instruction codes
`define OP_READ 8'h03
`define OP_WRITE 8'h02
`define OP_ENTER_DUAL 8'h3b
`define OP_ENTER_QUAD 8'h38
`define OP_EXIT_MULTI 8'hff
`define OP_READ_MODE 8'h05
`define OP_WRITE_MODE 8'h01

// mode register field and reset value
`define MODE_FIELD_HI 7
`define MODE_FIELD_LO 6
`define MODE_RESET 8'h40
`define MODE_BYTE 2'h0
`define MODE_PAGE 2'h2
`define MODE_SEQ 2'h1

// address layout
`define MEM_ADDR_W 19
`define ADDR_BYTES 2'h3
`define PAGE_BITS 5
`define DIE0_LAST 24'h03ffff

// read latency in clocks
`define DUAL_DUMMY_CYCLES 4
`define QUAD_DUMMY_CYCLES 2

`endif

//--- shared/sram_port_pkg.sv
// types shared by the serial sram command port
`default_nettype none
package sram_port_pkg;

  typedef enum logic [1:0] {
    IO_SINGLE,
    IO_DUAL,
    IO_QUAD
  } io_width_t;

  typedef enum logic [2:0] {
    ST_CMD,
    ST_ADDR,
    ST_DUMMY,
    ST_READ_DATA,
    ST_WRITE_DATA,
    ST_MODE_READ,
    ST_MODE_WRITE,
    ST_DONE
  } frame_state_t;

endpackage
`default_nettype wire

//--- tb/serial_sram_command_port_asserts.sv
// protocol checker for the serial sram command port
`timescale 1ns/1ps
`default_nettype none
module serial_sram_command_port_asserts #(
  parameter int ADDR_W = 19,
  parameter int QUAD_DUMMY = 2
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic [3:0] io_line_in,
  input wire logic [3:0] io_line_out,
  input wire logic [3:0] io_line_oe,
  input wire logic deselected,
  input wire logic [1:0] width_status,
  input wire logic [1:0] mode_status
);
  logic [7:0] edges;
  logic [7:0] opc;
  logic single;
  logic known;
  logic [3:0] lanes;
  logic [7:0] cmd_len;
  assign single = width_status == 2'h0;
  // opcode length in clocks shrinks with the bus width
  assign cmd_len = single ? 8'h08 : (width_status == 2'h1 ? 8'h04 : 8'h02);
  assign known = opc inside {8'h03, 8'h02, 8'h3b, 8'h38, 8'hff, 8'h05, 8'h01};
  assign lanes = single ? 4'h2 : (width_status == 2'h1 ? 4'h3 : 4'hf);
  // opcode is only meaningful on line 0, hence the single-width gating below
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      edges <= 8'h00;
      opc <= 8'h00;
    end else begin
      edges <= edges + {7'h0, edges != 8'hff};
      if (edges < 8'h08) opc <= {opc[6:0], io_line_in[0]};
    end
  end
  a_float_deselected: assert property (@(posedge clk) disable iff (!rstn)
    cs_n |-> io_line_oe == 4'h0) else $error("lines driven while deselected");
  a_idle_flag_up: assert property (@(posedge clk) disable iff (!rstn)
    $rose(cs_n) |-> ##[1:4] deselected) else $error("idle flag late");
  a_idle_flag_down: assert property (@(posedge clk) disable iff (!rstn)
    $fell(cs_n) |-> ##[1:4] !deselected) else $error("busy flag late");
  a_mode_default: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn) |-> mode_status == 2'h1 && single) else $error("bad reset mode");
  a_lane_width: assert property (@(posedge clk) disable iff (!rstn)
    io_line_oe != 4'h0 |-> io_line_oe == lanes) else $error("wrong lanes driven");
  a_quiet_command: assert property (@(posedge sck) disable iff (cs_n || !rstn)
    edges < cmd_len |-> io_line_oe == 4'h0) else $error("drive during opcode");
  a_read_launch: assert property (@(posedge sck) disable iff (cs_n || !rstn)
    single && opc == 8'h03 && edges inside {8'h1f, 8'h20}
    |-> io_line_oe == {2'b00, edges[5], 1'b0}) else $error("read start wrong");
  a_mode_reply: assert property (@(posedge sck) disable iff (cs_n || !rstn)
    single && opc == 8'h05 && edges == 8'h08 |-> io_line_oe == 4'h2)
    else $error("mode read silent");
  a_unknown_idle: assert property (@(posedge sck) disable iff (cs_n || !rstn)
    single && !known && edges >= 8'h08 |-> io_line_oe == 4'h0)
    else $error("unknown opcode answered");
  c_single_read: cover property (@(posedge sck) single && opc == 8'h03 && edges == 8'h20);
  c_mode_read: cover property (@(posedge sck) single && opc == 8'h05 && edges == 8'h08);
  c_quad: cover property (@(posedge clk) width_status == 2'h2);
endmodule
bind serial_sram_command_port serial_sram_command_port_asserts #(
  .ADDR_W(ADDR_W),
  .QUAD_DUMMY(QUAD_DUMMY)
) serial_sram_command_port_asserts_inst (
  .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .io_line_in(io_line_in),
  .io_line_out(io_line_out), .io_line_oe(io_line_oe), .deselected(deselected),
  .width_status(width_status), .mode_status(mode_status)
);
`default_nettype wire

//--- tb/sram_host_model.sv
// host serial controller model driving the sram command port
`timescale 1ns/1ps
`default_nettype none
module sram_host_model (
  output logic sck,
  output logic cs_n,
  output logic [3:0] io_line_in,
  input wire logic [3:0] io_line_out,
  input wire logic [3:0] io_line_oe
);
  logic [3:0] drv = 4'h0;
  logic [7:0] rx;
  assign io_line_in = (io_line_oe & io_line_out) | (~io_line_oe & drv);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
  end
  task automatic frame(input logic sel);
    #10;
    cs_n = !sel;
    #30;
  endtask
  task automatic xfer(input logic [7:0] tx, input int w);
    logic [3:0] nxt;
    for (int i = 8 - w; i >= 0; i -= w) begin
      // lines the host leaves alone toggle so stale values never look valid
      nxt = ~drv;
      for (int j = 0; j < w; j++) nxt[j] = tx[i + j];
      // one update per step, so the lines never glitch through a half-built value
      drv = nxt;
      #7.5 sck = 1'b1;
      for (int j = 0; j < w; j++) rx[i + j] = io_line_in[w == 1 ? 1 : j];
      #7.5 sck = 1'b0;
    end
  endtask
  task automatic cmd(input logic [7:0] op, input logic [23:0] a, input int w);
    xfer(op, w);
    for (int k = 2; k >= 0; k--) xfer(a[8*k +: 8], w);
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the serial sram command port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  wire sck;
  wire cs_n;
  wire desel;
  wire [3:0] io_in;
  wire [3:0] io_out;
  wire [3:0] io_oe;
  wire [1:0] width_status;
  wire [1:0] mode_status;
  int fails = 0;
  int total_checks = 0;
  always #5 clk = ~clk;
  serial_sram_command_port serial_sram_command_port_inst (
    .clk(clk), .rstn(rstn), .sck(sck), .cs_n(cs_n), .io_line_in(io_in),
    .io_line_out(io_out), .io_line_oe(io_oe), .deselected(desel),
    .width_status(width_status), .mode_status(mode_status)
  );
  sram_host_model sram_host_model_inst (
    .sck(sck), .cs_n(cs_n), .io_line_in(io_in), .io_line_out(io_out), .io_line_oe(io_oe)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xf(input logic [7:0] tx, input int w);
    sram_host_model_inst.xfer(tx, w);
  endtask
  task automatic fr(input logic sel);
    sram_host_model_inst.frame(sel);
  endtask
  task automatic wr(input logic [23:0] a, input logic [23:0] d, input int n, input int w);
    fr(1'b1);
    sram_host_model_inst.cmd(8'h02, a, w);
    for (int k = n - 1; k >= 0; k--) xf(d[8*k +: 8], w);
    fr(1'b0);
  endtask
  task automatic rd(input logic [23:0] a, input logic [23:0] e, input int n, input int w);
    fr(1'b1);
    sram_host_model_inst.cmd(8'h03, a, w);
    // dual latency is four clocks, quad two: one filler byte at the active width
    if (w > 1) xf(8'hff, w);
    for (int k = n - 1; k >= 0; k--) begin
      xf(8'hff, w);
      chk(sram_host_model_inst.rx, e[8*k +: 8]);
    end
    fr(1'b0);
  endtask
  task automatic ctl(input logic [7:0] op, input int w, input logic extra);
    fr(1'b1);
    xf(op, w);
    if (extra) xf(8'h00, w);
    fr(1'b0);
  endtask
  task automatic mset(input logic [7:0] d);
    fr(1'b1);
    xf(8'h01, 1);
    xf(d, 1);
    fr(1'b0);
  endtask
  task automatic mget(input logic [7:0] e);
    fr(1'b1);
    xf(8'h05, 1);
    xf(8'hff, 1);
    chk(sram_host_model_inst.rx, e);
    fr(1'b0);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk({6'h0, mode_status}, 8'h01);
    chk({7'h0, desel}, 8'h01);
    mget(8'h40);
    $display("reset test done");
    wr(24'hfbfffe, 24'ha1a2a3, 3, 1);
    rd(24'h000000, 24'h0000a3, 1, 1);
    rd(24'h03fffe, 24'ha1a2a3, 3, 1);
    ctl(8'h7e, 1, 1'b1);
    $display("sequential test done");
    mset(8'h80);
    mget(8'h80);
    chk({6'h0, mode_status}, 8'h02);
    wr(24'h00101e, 24'hb0b1b2, 3, 1);
    rd(24'h00101e, 24'hb0b1b2, 3, 1);
    rd(24'h001000, 24'h0000b2, 1, 1);
    wr(24'h002001, 24'h000077, 1, 1);
    $display("page test done");
    mset(8'h00);
    wr(24'h002000, 24'h00c0c1, 2, 1);
    mset(8'h40);
    rd(24'h002000, 24'h00c077, 2, 1);
    $display("byte test done");
    ctl(8'h3b, 1, 1'b0);
    chk({6'h0, width_status}, 8'h01);
    wr(24'h003000, 24'h0000d5, 1, 2);
    rd(24'h003000, 24'h0000d5, 1, 2);
    fr(1'b1);
    xf(8'h05, 2);
    xf(8'hff, 2);
    chk(sram_host_model_inst.rx, 8'h40);
    fr(1'b0);
    ctl(8'hff, 2, 1'b0);
    chk({6'h0, width_status}, 8'h00);
    ctl(8'h38, 1, 1'b0);
    chk({6'h0, width_status}, 8'h02);
    wr(24'h003001, 24'h0000e9, 1, 4);
    rd(24'h003000, 24'h00d5e9, 2, 4);
    ctl(8'hff, 4, 1'b0);
    chk({6'h0, width_status}, 8'h00);
    rd(24'h003001, 24'h0000e9, 1, 1);
    $display("multi line test done");
    wrap_up;
  end
  initial begin
    #300000;
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
